// ==== design/bas_pkg.sv ====
package bas_pkg;

   // Synchroniser depth; requests and acknowledges settle in at most two cycles
   localparam int SYNC_STAGES = 2;

   // Show-cycle enable field: two bits, both set means withhold the grant during internal transfers
   localparam int        SHOW_EN_W     = 2;
   localparam logic [1:0] SHOW_EN_ALL  = 2'h3;
   localparam logic [1:0] SHOW_EN_RST  = 2'h0;

   // Transfer size encoding: bytes remaining in the operand
   localparam int        SIZE_W        = 2;
   localparam logic [1:0] SIZE_LONG    = 2'h0;
   localparam logic [1:0] SIZE_BYTE    = 2'h1;
   localparam logic [1:0] SIZE_WORD    = 2'h2;
   localparam logic [1:0] SIZE_THREE   = 2'h3;

   // Port size acknowledge encoding (active low pair)
   localparam logic [1:0] ACK_BYTE_N   = 2'h2;
   localparam logic [1:0] ACK_WORD_N   = 2'h1;
   localparam logic [1:0] ACK_NONE_N   = 2'h3;

   // Data bus width
   localparam int        DATA_W        = 16;
   // Data line sampled during reset to enable slave mode
   localparam int        SLAVE_STRAP_BIT = 11;

   // Arbiter states
   typedef enum logic [1:0] {
      BAS_IDLE    = 2'b00,
      BAS_GRANT   = 2'b01,
      BAS_OWNED   = 2'b10,
      BAS_REGRANT = 2'b11
   } bas_arb_type;

   // Show-cycle states
   typedef enum logic [1:0] {
      BAS_SHOW_ADDR  = 2'b00,
      BAS_SHOW_STRB  = 2'b01,
      BAS_SHOW_WAIT  = 2'b10,
      BAS_SHOW_END   = 2'b11
   } bas_show_type;

endpackage : bas_pkg

// ==== design/bas_arbiter.sv ====
// Summary of operation
// - Keep bus through multi-cycle operand transfers
// - Grant only after the operand's last cycle
// - No grant while locked cycle asserted
// - Both show bits withhold grant during internal
// - Ownership ends when acknowledge negates
// - Request still held means grant again
// - Pending requests keep the bus away
// - Acknowledge alone never causes a grant
// - Synchronise request and acknowledge, two flops
// - Float buses after strobe and lock negate
// - State changes on edge after sync valid
// - Grant pin changes on following falling edge
// - Resume driving control one cycle after return to idle
// - Idle while owner: grant and float negated
// - Ignore request during locked sequence
// - Slave mode only from strap low at reset
// - Slave internal transfer: wait cycle and lock
// - Slave external transfer: force processor off
// - Slave master reaches all internal registers
// - Show cycles off after reset, strobes negated
// - Show on: data strobe and data driven
// - Show sequence: address, strobe, wait, negate
`timescale 1ns/1ns
module bas_arbiter
   import bas_pkg::*;
#(
   parameter int DW = DATA_W
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // External arbitration pins
   input  wire logic              bus_request_n,
   input  wire logic              grant_acknowledge_n,
   output logic                   bus_grant_n,
   // Strap sampled while reset is applied
   input  wire logic              slave_strap_data_line,
   // Processor access status
   input  wire logic              ext_xfer,
   input  wire logic              int_xfer,
   input  wire logic              locked_cycle_n,
   input  wire logic              address_strobe_int_n,
   input  wire logic [SIZE_W-1:0] transfer_size,
   input  wire logic [1:0]        port_size_ack_n,
   input  wire logic [SHOW_EN_W-1:0] show_cycle_enable,
   input  wire logic [DW-1:0]     int_data,
   // Outputs to the bus drivers and processor
   output logic                   bus_float,
   output logic                   ctrl_drive,
   output logic                   cpu_force_off,
   output logic                   slave_mode_enable,
   output logic                   slave_access,
   output logic                   data_strobe_n,
   output logic                   address_strobe_n,
   output logic [DW-1:0]          data_out,
   output logic                   data_oe
);

   // Two-stage synchronisers; first stage feeds only the second
   logic [SYNC_STAGES-1:0] reqSync_ff;
   logic [SYNC_STAGES-1:0] ackSync_ff;
   wire                    reqS = reqSync_ff[SYNC_STAGES-1];
   wire                    ackS = ackSync_ff[SYNC_STAGES-1];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reqSync_ff <= '0;
         ackSync_ff <= '0;
      end else begin
         reqSync_ff <= {reqSync_ff[SYNC_STAGES-2:0], ~bus_request_n};
         ackSync_ff <= {ackSync_ff[SYNC_STAGES-2:0], ~grant_acknowledge_n};
      end
   end

   // Strap capture: sampled every clock while reset is on, frozen after release
   logic slaveEn_ff;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slaveEn_ff <= ~slave_strap_data_line;
      end
   end
   assign slave_mode_enable = slaveEn_ff;

   // True when this acknowledge completes the current operand
   function automatic logic last_cycle(input logic [SIZE_W-1:0] sz,
                                       input logic [1:0]        ack);
      logic [2:0] bytes;
      logic [2:0] port;
      bytes = (sz == SIZE_LONG) ? 3'h4 : {1'b0, sz};
      port  = (ack == ACK_BYTE_N) ? 3'h1 : ((ack == ACK_NONE_N) ? 3'h0 : 3'h2);
      last_cycle = (port != 3'h0) && (port >= bytes);
   endfunction : last_cycle

   // Operand coherency: busy from first cycle until the final acknowledge
   logic operandBusy_ff;
   wire  lockOn    = ~locked_cycle_n;
   wire  endOfOp   = ext_xfer && last_cycle(transfer_size, port_size_ack_n);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         operandBusy_ff <= 1'b0;
      end else begin
         operandBusy_ff <= ext_xfer && !endOfOp;
      end
   end

   // Grant holds: coherency, lock, show-cycle and slave-mode restraints
   wire extHold   = (ext_xfer && !endOfOp) || operandBusy_ff;
   wire lockHold  = lockOn;
   wire showHold  = (show_cycle_enable == SHOW_EN_ALL) && int_xfer;
   wire slaveHold = slaveEn_ff && int_xfer;
   wire slaveExt  = slaveEn_ff && ext_xfer;
   wire normHold  = slaveEn_ff ? (slaveHold || lockHold || ext_xfer)
                               : (extHold || lockHold || showHold);
   wire reqValid  = reqS && !lockOn;
   wire grantOk   = reqValid && !normHold;

   // Arbiter state machine
   bas_arb_type state_ff;
   bas_arb_type nxt_state;
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         BAS_IDLE: begin
            if (grantOk) nxt_state = BAS_GRANT;
         end
         BAS_GRANT: begin
            // A lock that starts after the grant takes it back unless the acknowledge is already seen
            if (ackS) nxt_state = BAS_OWNED;
            else if (!reqS || lockOn) nxt_state = BAS_IDLE;
         end
         BAS_OWNED: begin
            if (reqS) nxt_state = BAS_REGRANT;
            else if (!ackS) nxt_state = BAS_IDLE;
         end
         BAS_REGRANT: begin
            if (!ackS) nxt_state = reqS ? BAS_GRANT : BAS_IDLE;
            else if (!reqS) nxt_state = BAS_OWNED;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) state_ff <= BAS_IDLE;
      else     state_ff <= nxt_state;
   end

   // Internal grant and three-state control per state
   wire grantInt = (state_ff == BAS_GRANT) || (state_ff == BAS_REGRANT);
   wire floatInt = (state_ff != BAS_IDLE);

   // Grant pin moves on the falling edge so it settles mid-cycle
   logic grantN_ff;
   always_ff @(negedge ref_clk or posedge rst) begin
      if (rst) grantN_ff <= 1'b1;
      else     grantN_ff <= ~grantInt;
   end
   assign bus_grant_n = grantN_ff;

   // Float only after strobe and lock are both negated
   logic float_ff;
   wire  quiet = address_strobe_int_n && locked_cycle_n;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) float_ff <= 1'b0;
      else if (!floatInt) float_ff <= 1'b0;
      else if (quiet) float_ff <= 1'b1;
   end
   assign bus_float     = float_ff;
   assign ctrl_drive    = !floatInt && !float_ff;
   assign cpu_force_off = slaveExt && reqS && (state_ff == BAS_IDLE);
   assign slave_access  = slaveEn_ff && floatInt;

   // Show-cycle sequencer, started only while enabled and bus is ours
   bas_show_type show_ff;
   bas_show_type nxt_show;
   wire showOn = (show_cycle_enable != SHOW_EN_RST) && ctrl_drive;
   always_comb begin
      nxt_show = show_ff;
      unique case (show_ff)
         BAS_SHOW_ADDR: if (int_xfer && showOn) nxt_show = BAS_SHOW_STRB;
         BAS_SHOW_STRB: nxt_show = BAS_SHOW_WAIT;
         BAS_SHOW_WAIT: if (!int_xfer) nxt_show = BAS_SHOW_END;
         BAS_SHOW_END:  nxt_show = BAS_SHOW_ADDR;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) show_ff <= BAS_SHOW_ADDR;
      else     show_ff <= nxt_show;
   end

   // Strobe asserted half a clock after address, on the falling edge
   logic dsN_ff;
   wire  dsWant = (show_ff == BAS_SHOW_STRB) || (show_ff == BAS_SHOW_WAIT);
   always_ff @(negedge ref_clk or posedge rst) begin
      if (rst) dsN_ff <= 1'b1;
      else     dsN_ff <= ~dsWant;
   end
   assign data_strobe_n    = dsN_ff;
   assign address_strobe_n = 1'b1; // Never asserted during show cycles

   // Show data captured while internal access runs, held into next cycle
   logic [DW-1:0] data_ff;
   logic          oe_ff;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         data_ff <= '0;
         oe_ff   <= 1'b0;
      end else begin
         if (show_ff == BAS_SHOW_WAIT) data_ff <= int_data;
         oe_ff <= (show_ff != BAS_SHOW_ADDR) || (dsWant && showOn);
      end
   end
   assign data_out = data_ff;
   assign data_oe  = oe_ff;

endmodule : bas_arbiter

// ==== testbench/bas_master.sv ====
`timescale 1ns/1ns
module bas_master (
   // Bench commands
   input  wire logic       ref_clk,
   input  wire logic       go,
   input  wire logic       keepReq,
   input  wire logic [3:0] holdLen,
   // Arbitration pins
   input  wire logic       bus_grant_n,
   output logic            bus_request_n,
   output logic            grant_acknowledge_n,
   output logic            done
);
   logic [3:0] hold_ff;
   initial begin
      bus_request_n = 1'b1;
      grant_acknowledge_n = 1'b1;
      done = 1'b0;
      hold_ff = 4'h0;
   end
   // Claim only on a grant with no owner; holdLen sets a prompt or slow master
   always @(posedge ref_clk) begin
      done <= 1'b0;
      if (!grant_acknowledge_n) begin
         hold_ff <= hold_ff + 4'h1;
         if (hold_ff == holdLen) begin
            grant_acknowledge_n <= 1'b1;
            bus_request_n <= 1'b1;
            done <= 1'b1;
         end
      end else if (!bus_request_n && !bus_grant_n) begin
         grant_acknowledge_n <= 1'b0;
         bus_request_n <= !keepReq;
         hold_ff <= 4'h0;
      end else if (go) begin
         bus_request_n <= 1'b0;
      end
   end
endmodule : bas_master

// ==== testbench/bas_chk.sv ====
`timescale 1ns/1ns
module bas_chk
   import bas_pkg::*;
(
   // Watched ports
   input wire logic                 ref_clk, rst, bus_request_n, grant_acknowledge_n,
   input wire logic                 bus_grant_n, ext_xfer, int_xfer, locked_cycle_n,
   input wire logic [SHOW_EN_W-1:0] show_cycle_enable,
   input wire logic                 ctrl_drive, bus_float, slave_mode_enable,
   input wire logic                 data_strobe_n, address_strobe_n, data_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Nothing that may hold back a grant
   wire quiet = grant_acknowledge_n && locked_cycle_n && !int_xfer && !ext_xfer;
   property p_noreq; bus_request_n [*4] |-> bus_grant_n; endproperty
   a_noreq: assert property (p_noreq) else $error("grant without request");
   property p_lock; $fell(bus_grant_n) |-> $past(locked_cycle_n); endproperty
   a_lock: assert property (p_lock) else $error("grant during lock");
   property p_show; $fell(bus_grant_n) |-> !($past(int_xfer) && show_cycle_enable == SHOW_EN_ALL);
   endproperty
   a_show: assert property (p_show) else $error("grant during internal access");
   property p_grant; (quiet && !bus_request_n) [*7] |-> !bus_grant_n; endproperty
   a_grant: assert property (p_grant) else $error("grant missing");
   property p_owned; !bus_grant_n ##1 !grant_acknowledge_n [*4] |-> !ctrl_drive; endproperty
   a_owned: assert property (p_owned) else $error("drives while not owner");
   property p_idle; (bus_request_n && grant_acknowledge_n) [*5]
      |-> ctrl_drive && bus_grant_n && !bus_float; endproperty
   a_idle: assert property (p_idle) else $error("not idle");
   property p_off; (show_cycle_enable == SHOW_EN_RST) [*4] |-> data_strobe_n && !data_oe;
   endproperty
   a_off: assert property (p_off) else $error("strobe while show off");
   property p_as; address_strobe_n; endproperty
   a_as: assert property (p_as) else $error("address strobe asserted");
   property p_on; $rose(int_xfer) && show_cycle_enable != SHOW_EN_RST |-> ##[2:3] !data_strobe_n;
   endproperty
   a_on: assert property (p_on) else $error("no show strobe");
   property p_strap; $stable(slave_mode_enable); endproperty
   a_strap: assert property (p_strap) else $error("slave mode changed");
   c_grant: cover property ($fell(bus_grant_n));
   c_show: cover property ($fell(data_strobe_n));
   c_slave: cover property (slave_mode_enable && !bus_grant_n);
endmodule : bas_chk
bind bas_arbiter bas_chk u_chk (.ref_clk, .rst, .bus_request_n, .grant_acknowledge_n,
   .bus_grant_n, .ext_xfer, .int_xfer, .locked_cycle_n, .show_cycle_enable, .ctrl_drive,
   .bus_float, .slave_mode_enable, .data_strobe_n, .address_strobe_n, .data_oe);

// ==== testbench/bus_arbitration_show_cycles_tb.sv ====
`timescale 1ns/1ns
module bus_arbitration_show_cycles_tb;
   import bas_pkg::*;
   // Bench drives, design answers
   logic              ref_clk = 1'b0, rst = 1'b1, go = 1'b0, keepReq = 1'b0, strap = 1'b1;
   logic              extX = 1'b0, intX = 1'b0, lockN = 1'b1, regrant = 1'b0, gPrev = 1'b1;
   logic [3:0]        holdLen = 4'h8;
   logic [1:0]        showEn = 2'h0;
   logic [1:0]        sizeIn = SIZE_BYTE, ackIn = ACK_BYTE_N;
   logic              reqN, ackN, grantN, done, ctrlDrv, busFloat, forceOff, slaveEn, dsN, oe;
   logic [DATA_W-1:0] dOut;
   int                failCount = 0, testsRun = 0;
   bas_arbiter u_dut (.ref_clk(ref_clk), .rst(rst), .bus_request_n(reqN),
      .grant_acknowledge_n(ackN), .bus_grant_n(grantN), .slave_strap_data_line(strap),
      .ext_xfer(extX), .int_xfer(intX), .locked_cycle_n(lockN), .address_strobe_int_n(1'b1),
      .transfer_size(sizeIn), .port_size_ack_n(ackIn), .show_cycle_enable(showEn),
      .int_data(16'h5a3c), .bus_float(busFloat), .ctrl_drive(ctrlDrv), .cpu_force_off(forceOff),
      .slave_mode_enable(slaveEn), .slave_access(), .data_strobe_n(dsN), .address_strobe_n(),
      .data_out(dOut), .data_oe(oe));
   bas_master u_mst (.ref_clk(ref_clk), .go(go), .keepReq(keepReq), .holdLen(holdLen),
      .bus_grant_n(grantN), .bus_request_n(reqN), .grant_acknowledge_n(ackN), .done(done));
   always #10 ref_clk = ~ref_clk;
   // A fresh grant while a master still acknowledges
   always @(posedge ref_clk) begin
      if (ackN === 1'b0 && grantN === 1'b0 && gPrev === 1'b1) regrant <= 1'b1;
      gPrev <= grantN;
   end
   task automatic tick(input int n); repeat (n) @(posedge ref_clk); #1; endtask : tick
   task automatic chk(input logic ok, input string msg);
      testsRun++;
      if (ok !== 1'b1) begin
         $display("wrong value at %0t: %s", $time, msg);
         failCount++;
      end
   endtask : chk
   task automatic ask(input logic keep);
      @(posedge ref_clk) go <= 1'b1;
      keepReq <= keep;
      @(posedge ref_clk) go <= 1'b0;
   endtask : ask
   // Bounded waits for the grant and for the master to finish
   task automatic wgrant(input int lim);
      for (int k = 0; k < lim && grantN !== 1'b0; k++) tick(1);
      chk(grantN === 1'b0, "grant late");
   endtask : wgrant
   task automatic wdone();
      for (int k = 0; k < 30 && done !== 1'b1; k++) tick(1);
      tick(6);
      chk(ctrlDrv === 1'b1 && grantN === 1'b1 && busFloat === 1'b0, "not back");
   endtask : wdone
   task automatic t_basic();
      chk(slaveEn === 1'b0, "slave");
      ask(0);
      wgrant(6);
      tick(6);
      chk(ctrlDrv === 1'b0, "drives");
      wdone();
      $display("done basic");
   endtask : t_basic
   task automatic t_lock();
      @(posedge ref_clk) lockN <= 1'b0;
      ask(0);
      tick(10);
      chk(grantN === 1'b1, "lock");
      @(posedge ref_clk) lockN <= 1'b1;
      wgrant(8);
      wdone();
      $display("done lock");
   endtask : t_lock
   task automatic t_show();
      @(posedge ref_clk) showEn <= SHOW_EN_ALL;
      intX <= 1'b1;
      ask(0);
      tick(8);
      chk(grantN === 1'b1 && dsN === 1'b0 && oe === 1'b1, "show");
      @(posedge ref_clk) intX <= 1'b0;
      tick(3);
      chk(dOut === 16'h5a3c, "data");
      wgrant(8);
      wdone();
      @(posedge ref_clk) showEn <= SHOW_EN_RST;
      tick(5);
      chk(dsN === 1'b1 && oe === 1'b0, "show off");
      $display("done show");
   endtask : t_show
   task automatic t_regrant();
      holdLen <= 4'hc;
      ask(1);
      wgrant(6);
      wdone();
      chk(regrant === 1'b1, "regrant");
      holdLen <= 4'h2;
      $display("done regrant");
   endtask : t_regrant
   // Word operand on byte acknowledges keeps the bus until a word acknowledge ends it
   task automatic t_operand();
      @(posedge ref_clk) extX <= 1'b1;
      sizeIn <= SIZE_WORD;
      ackIn <= ACK_BYTE_N;
      ask(0);
      tick(10);
      chk(grantN === 1'b1, "operand split");
      @(posedge ref_clk) ackIn <= ACK_WORD_N;
      wgrant(8);
      @(posedge ref_clk) extX <= 1'b0;
      sizeIn <= SIZE_BYTE;
      ackIn <= ACK_BYTE_N;
      wdone();
      $display("done operand");
   endtask : t_operand
   task automatic t_slave();
      @(posedge ref_clk) rst <= 1'b1;
      strap <= 1'b0;
      tick(10);
      rst <= 1'b0;
      strap <= 1'b1;
      tick(2);
      chk(slaveEn === 1'b1, "strap");
      @(posedge ref_clk) extX <= 1'b1;
      ask(0);
      tick(8);
      chk(forceOff === 1'b1 && grantN === 1'b1, "force off");
      @(posedge ref_clk) extX <= 1'b0;
      wgrant(8);
      wdone();
      $display("done slave");
   endtask : t_slave
   task automatic conclude();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   initial begin
      tick(10);
      rst <= 1'b0;
      t_basic();
      t_lock();
      t_show();
      t_regrant();
      t_operand();
      t_slave();
      conclude();
   end
   // Hang guard, far beyond the expected run length
   initial begin
      repeat (3000) @(posedge ref_clk);
      failCount++;
      conclude();
   end
endmodule : bus_arbitration_show_cycles_tb
